/* File: design/mmdp_pkg.sv */
package mmdp_pkg;

  // microword layout
  localparam int UW_W        = 16;
  localparam int BYTE_W      = 8;
  localparam int REG_AW      = 4;
  localparam int IDX_W       = 3;
  localparam int XLATE_W     = 16;
  localparam int FLAG_W      = 8;

  localparam int A_FIELD_LO  = 0;
  localparam int A_FIELD_HI  = 3;
  localparam int B_FIELD_LO  = 4;
  localparam int B_FIELD_HI  = 7;
  localparam int LIT_LO      = 4;
  localparam int LIT_HI      = 11;
  localparam int SETCC_BIT   = 8;
  localparam int LCF_C_BIT   = 4;
  localparam int LCF_V_BIT   = 5;
  localparam int LCF_Z_BIT   = 6;
  localparam int LCF_N_BIT   = 7;

  // opcode match values
  localparam logic [3:0] OPC_LIT_TOP    = 4'h6;   // bits 15:12, 06xxxx
  localparam logic [7:0] OPC_INDEX_LOW  = 8'h75;  // bits 15:8, 072400-072777
  localparam logic [7:0] OPC_XLATE      = 8'hee;  // bits 15:8, 167000-167377
  localparam logic [7:0] OPC_COPY_FLAGS = 8'h72;  // bits 15:8, 071000-071377
  localparam logic [7:0] OPC_LOAD_FLAGS = 8'h73;  // bits 15:8, 071400-071777
  localparam logic [6:0] OPC_MOVE_BYTE  = 7'h40;  // bits 15:9, 100000-100777
  localparam logic [6:0] OPC_COND_MOVE  = 7'h42;  // bits 15:9, 102000-102777

  // flag register bit positions
  localparam int FLAG_NB = 7;
  localparam int FLAG_ZB = 6;
  localparam int FLAG_C4 = 5;
  localparam int FLAG_C8 = 4;
  localparam int FLAG_N  = 3;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_V  = 1;
  localparam int FLAG_C  = 0;

  localparam logic [FLAG_W-1:0]  FLAGS_RST = 8'h00;
  localparam logic [BYTE_W-1:0]  REG_RST   = 8'h00;
  localparam logic [IDX_W-1:0]   IDX_RST   = 3'h0;
  localparam logic [XLATE_W-1:0] XLATE_RST = 16'h0000;

  typedef enum logic [7:0] {
    MMDP_OP_NONE  = 8'h01,
    MMDP_OP_LIT   = 8'h02,
    MMDP_OP_INDEX = 8'h04,
    MMDP_OP_XLATE = 8'h08,
    MMDP_OP_COPYF = 8'h10,
    MMDP_OP_LOADF = 8'h20,
    MMDP_OP_MOVE  = 8'h40,
    MMDP_OP_CMOVE = 8'h80
  } mmdp_op_t;

endpackage : mmdp_pkg

/* File: design/mmdp_core.sv */
// Overview of operation
// - The destination register number comes from microword bits 3:0 and the source from 7:4.
// - Load-constant (06xxxx) writes microword bits 11:4 into the destination in one cycle.
// - Load-constant updates byte-negative and byte-zero only, leaving carries and codes.
// - Load-index-low copies destination bits 2:0 into the index register, nothing else.
// - The 3-bit index register serves indirect addressing and changes only by two paths.
// - Load-translation loads source:destination into the 16-bit translation register.
// - Copy-flags writes the whole flag register into the destination, flags unchanged.
// - Flag layout is NB, ZB, half carry, byte carry in 7:4 and N, Z, V, C in 3:0.
// - Load-flags always loads NB, ZB and both carries from destination bits 7:4.
// - Load-flags loads C, V, Z, N from bits 0..3 only where microword bit 4..7 is one.
// - Move-byte copies source to destination and updates byte-negative and byte-zero.
// - The setcc move also sets N and Z, clears V, and leaves C and both carries.
// - Conditional move copies the byte only when the carry code was one beforehand.
// - Conditional move touches flags only when carry was one, else nothing changes.
// - Every operation completes internally with no system bus transfer.
`timescale 1ns/1ps
`default_nettype none

module mmdp_core #(
  parameter int NREGS = 16
) (
  // clock and reset
  input  wire logic                           i_clk,
  input  wire logic                           i_nrst,
  // microinstruction issue
  input  wire logic                           i_exec,
  input  wire logic [mmdp_pkg::UW_W-1:0]      i_ucode_word,
  // input-word side path into index and translation registers
  input  wire logic                           i_in_word_load,
  input  wire logic [mmdp_pkg::XLATE_W-1:0]   i_in_word,
  input  wire logic [mmdp_pkg::IDX_W-1:0]     i_in_index,
  // register read port
  input  wire logic                           i_rd_indirect,
  input  wire logic [mmdp_pkg::REG_AW-1:0]    i_rd_addr,
  output var  logic [mmdp_pkg::BYTE_W-1:0]    o_rd_data,
  // state out
  output var  logic [mmdp_pkg::FLAG_W-1:0]    o_flags,
  output var  logic [mmdp_pkg::IDX_W-1:0]     o_index,
  output var  logic [mmdp_pkg::XLATE_W-1:0]   o_xlate,
  output var  logic                           o_done,
  output var  logic                           o_cond_taken,
  output var  logic                           o_unknown_op
);
  import mmdp_pkg::*;

  function automatic mmdp_op_t decode_op(input logic [UW_W-1:0] uw);
    mmdp_op_t op;
    op = MMDP_OP_NONE;
    if (uw[15:12] == OPC_LIT_TOP) begin
      op = MMDP_OP_LIT;
    end else if (uw[15:8] == OPC_INDEX_LOW) begin
      op = MMDP_OP_INDEX;
    end else if (uw[15:8] == OPC_XLATE) begin
      op = MMDP_OP_XLATE;
    end else if (uw[15:8] == OPC_COPY_FLAGS) begin
      op = MMDP_OP_COPYF;
    end else if (uw[15:8] == OPC_LOAD_FLAGS) begin
      op = MMDP_OP_LOADF;
    end else if (uw[15:9] == OPC_MOVE_BYTE) begin
      op = MMDP_OP_MOVE;
    end else if (uw[15:9] == OPC_COND_MOVE) begin
      op = MMDP_OP_CMOVE;
    end
    return op;
  endfunction : decode_op

  // indirect access keeps the bank bit and swaps the low bits for the index
  function automatic logic [REG_AW-1:0] eff_addr(input logic             ind,
                                                 input logic [REG_AW-1:0] a,
                                                 input logic [IDX_W-1:0]  g);
    return ind ? {a[REG_AW-1], g} : a;
  endfunction : eff_addr

  logic [BYTE_W-1:0]  regs      [NREGS];
  logic [BYTE_W-1:0]  next_regs [NREGS];
  logic [FLAG_W-1:0]  flags;
  logic [FLAG_W-1:0]  next_flags;
  logic [IDX_W-1:0]   index;
  logic [IDX_W-1:0]   next_index;
  logic [XLATE_W-1:0] xlate;
  logic [XLATE_W-1:0] next_xlate;
  logic [BYTE_W-1:0]  rd_data;
  logic [BYTE_W-1:0]  next_rd_data;
  logic               done;
  logic               next_done;
  logic               cond_taken;
  logic               next_cond_taken;
  logic               unknown_op;
  logic               next_unknown_op;

  mmdp_op_t           op;
  logic [REG_AW-1:0]  a_sel;
  logic [REG_AW-1:0]  b_sel;
  logic [BYTE_W-1:0]  a_val;
  logic [BYTE_W-1:0]  b_val;
  logic [BYTE_W-1:0]  result;
  logic               wr_en;
  logic               setcc;

  assign op    = decode_op(i_ucode_word);
  assign a_sel = i_ucode_word[A_FIELD_HI:A_FIELD_LO];
  assign b_sel = i_ucode_word[B_FIELD_HI:B_FIELD_LO];
  assign a_val = regs[a_sel];
  assign b_val = regs[b_sel];
  assign setcc = i_ucode_word[SETCC_BIT];

  // execution: every operation finishes in the cycle it is issued
  always_comb begin
    next_flags      = flags;
    next_index      = index;
    next_xlate      = xlate;
    next_done       = 1'b0;
    next_cond_taken = 1'b0;
    next_unknown_op = 1'b0;
    result          = REG_RST;
    wr_en           = 1'b0;

    // input-word path: the only other way the index register changes
    if (i_in_word_load) begin
      next_index = i_in_index;
      next_xlate = i_in_word;
    end

    if (i_exec) begin
      next_done = 1'b1;
      unique case (op)
        MMDP_OP_LIT: begin
          result = i_ucode_word[LIT_HI:LIT_LO];
          wr_en  = 1'b1;
          next_flags[FLAG_NB] = result[BYTE_W-1];
          next_flags[FLAG_ZB] = (result == REG_RST);
        end
        MMDP_OP_INDEX: begin
          next_index = a_val[IDX_W-1:0];
        end
        MMDP_OP_XLATE: begin
          next_xlate = {b_val, a_val};
        end
        MMDP_OP_COPYF: begin
          result = flags;
          wr_en  = 1'b1;
        end
        MMDP_OP_LOADF: begin
          next_flags[FLAG_NB] = a_val[FLAG_NB];
          next_flags[FLAG_ZB] = a_val[FLAG_ZB];
          next_flags[FLAG_C4] = a_val[FLAG_C4];
          next_flags[FLAG_C8] = a_val[FLAG_C8];
          if (i_ucode_word[LCF_C_BIT]) begin
            next_flags[FLAG_C] = a_val[FLAG_C];
          end
          if (i_ucode_word[LCF_V_BIT]) begin
            next_flags[FLAG_V] = a_val[FLAG_V];
          end
          if (i_ucode_word[LCF_Z_BIT]) begin
            next_flags[FLAG_Z] = a_val[FLAG_Z];
          end
          if (i_ucode_word[LCF_N_BIT]) begin
            next_flags[FLAG_N] = a_val[FLAG_N];
          end
        end
        MMDP_OP_MOVE, MMDP_OP_CMOVE: begin
          // conditional form tests carry as it stood before this cycle
          if (op == MMDP_OP_MOVE || flags[FLAG_C]) begin
            next_cond_taken = (op == MMDP_OP_CMOVE);
            result = b_val;
            wr_en  = 1'b1;
            next_flags[FLAG_NB] = result[BYTE_W-1];
            next_flags[FLAG_ZB] = (result == REG_RST);
            if (setcc) begin
              next_flags[FLAG_N] = result[BYTE_W-1];
              next_flags[FLAG_Z] = (result == REG_RST);
              next_flags[FLAG_V] = 1'b0;
            end
          end
        end
        MMDP_OP_NONE: begin
          next_unknown_op = 1'b1;
        end
      endcase
    end
  end

  // register file next values
  generate
    for (genvar r = 0; r < NREGS; r++) begin : g_reg
      always_comb begin
        next_regs[r] = regs[r];
        if (wr_en && (a_sel == REG_AW'(r))) begin
          next_regs[r] = result;
        end
      end
    end
  endgenerate

  always_comb begin
    next_rd_data = next_regs[eff_addr(i_rd_indirect, i_rd_addr, next_index)];
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      for (int r = 0; r < NREGS; r++) begin
        regs[r] <= REG_RST;
      end
      flags      <= FLAGS_RST;
      index      <= IDX_RST;
      xlate      <= XLATE_RST;
      rd_data    <= REG_RST;
      done       <= 1'b0;
      cond_taken <= 1'b0;
      unknown_op <= 1'b0;
    end else begin
      for (int r = 0; r < NREGS; r++) begin
        regs[r] <= next_regs[r];
      end
      flags      <= next_flags;
      index      <= next_index;
      xlate      <= next_xlate;
      rd_data    <= next_rd_data;
      done       <= next_done;
      cond_taken <= next_cond_taken;
      unknown_op <= next_unknown_op;
    end
  end

  assign o_rd_data    = rd_data;
  assign o_flags      = flags;
  assign o_index      = index;
  assign o_xlate      = xlate;
  assign o_done       = done;
  assign o_cond_taken = cond_taken;
  assign o_unknown_op = unknown_op;

endmodule : mmdp_core

`default_nettype wire

/* File: testbench/mmdp_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module mmdp_chk (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_nrst,
  // issue and read port
  input wire logic        i_exec,
  input wire logic [15:0] i_ucode_word,
  input wire logic        i_in_word_load,
  input wire logic        i_rd_indirect,
  input wire logic [3:0]  i_rd_addr,
  // state
  input wire logic [7:0]  o_rd_data,
  input wire logic [7:0]  o_flags,
  input wire logic [2:0]  o_index,
  input wire logic        o_done,
  input wire logic        o_cond_taken
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire [7:0] op  = i_ucode_word[15:8];
  wire       rdd = !i_rd_indirect && i_rd_addr == i_ucode_word[3:0];
  wire       lit = i_exec && i_ucode_word[15:12] == 4'h6;
  wire       mv  = i_exec && op[7:1] == 7'h40;
  wire       cm  = i_exec && op[7:1] == 7'h42;
  chk_done_pulse: assert property (i_exec |=> o_done) else $error("no done");
  chk_done_idle: assert property (!i_exec |=> !o_done) else $error("stray done");
  chk_lit_write: assert property (
    lit && rdd |=> o_rd_data == $past(i_ucode_word[11:4])) else $error("literal lost");
  chk_lit_flags: assert property (lit |=> o_flags[7] == o_rd_data[7] || !$past(rdd))
    else $error("literal sign");
  chk_lit_keep: assert property (
    lit |=> o_flags[5:0] == $past(o_flags[5:0])) else $error("literal flags");
  chk_index_hold: assert property (
    !(i_exec && op == 8'h75) && !i_in_word_load |=> $stable(o_index)) else $error("index moved");
  chk_quiet_flags: assert property (
    i_exec && (op == 8'h75 || op == 8'hee) |=> $stable(o_flags)) else $error("flags moved");
  chk_copy_flags: assert property (
    i_exec && op == 8'h72 && rdd |=> o_rd_data == $past(o_flags)) else $error("copy flags");
  chk_load_flags: assert property (
    i_exec && op == 8'h73 && rdd |=> o_flags[7:4] == o_rd_data[7:4]
    && o_flags[3:0] == (($past(i_ucode_word[7:4]) & o_rd_data[3:0])
    | (~$past(i_ucode_word[7:4]) & $past(o_flags[3:0])))) else $error("load flags");
  chk_move_cc: assert property (
    mv && i_ucode_word[8] |=> o_flags[3:2] == o_flags[7:6]
    && !o_flags[1] && o_flags[0] == $past(o_flags[0])) else $error("move codes");
  chk_cmove_skip: assert property (
    cm && !o_flags[0] |=> $stable(o_flags) && !o_cond_taken) else $error("cmove skip");
  chk_cmove_take: assert property (cm && o_flags[0] |=> o_cond_taken) else $error("cmove");
  cover property (lit && rdd);
  cover property (cm && o_flags[0]);
  cover property (i_exec && op == 8'h73 && rdd);
endmodule : mmdp_chk
bind mmdp_core mmdp_chk u_chk (.i_clk, .i_nrst, .i_exec, .i_ucode_word, .i_in_word_load,
  .i_rd_indirect, .i_rd_addr, .o_rd_data, .o_flags, .o_index, .o_done, .o_cond_taken);
`default_nettype wire

/* File: testbench/mmdp_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module mmdp_seq (
  // clock and pacing
  input wire logic         i_clk,
  input wire logic         i_slow,
  // microinstruction bus
  output var logic         o_exec,
  output var logic [15:0]  o_word
);
  logic [15:0] q[$];
  initial begin
    o_exec = 1'b0;
    o_word = 16'h0000;
  end
  // slow pacing leaves a gap after each word; an idle bus shows garbage
  always @(posedge i_clk) begin
    if (q.size() != 0 && !(i_slow && o_exec)) begin
      o_exec <= 1'b1;
      o_word <= q.pop_front();
    end else begin
      o_exec <= 1'b0;
      o_word <= ~o_word;
    end
  end
endmodule : mmdp_seq
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_clk = 0, i_nrst, i_in_word_load, i_rd_indirect, slow, i_exec, dn, ct, uk;
  logic [15:0] i_ucode_word, i_in_word, xl;
  logic [3:0]  i_rd_addr;
  logic [2:0]  i_in_index, o_index, ix;
  logic [7:0]  o_rd_data, o_flags, fl, rd, mr[16];
  logic [15:0] o_xlate;
  logic        o_done, o_cond_taken, o_unknown_op;
  integer      seed = 32'h18e3;
  int          miscompares = 0, comparisons = 0;
  always #5 i_clk = ~i_clk;
  mmdp_seq u_seq (.i_clk, .i_slow(slow), .o_exec(i_exec), .o_word(i_ucode_word));
  mmdp_core u_dut (.i_clk, .i_nrst, .i_exec, .i_ucode_word, .i_in_word_load, .i_in_word,
    .i_in_index, .i_rd_indirect, .i_rd_addr, .o_rd_data, .o_flags, .o_index, .o_xlate,
    .o_done, .o_cond_taken, .o_unknown_op);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  function automatic logic [15:0] mk(int k);
    logic [15:0] w;
    w = 16'($random(seed));
    w[3:2] = 2'b00;
    case (k)
      0: w[15:12] = 4'h6;
      1: w[15:8] = 8'h75;
      2: w[15:8] = 8'hee;
      3: w[15:8] = 8'h72;
      4: w[15:8] = 8'h73;
      5: w[15:9] = 7'h40;
      6: w[15:9] = 7'h42;
      default: w[15:12] = 4'hf;
    endcase
    return w;
  endfunction : mk
  always @(posedge i_clk) begin : model
    logic [7:0] f;
    logic [3:0] a;
    a = i_ucode_word[3:0];
    f = fl;
    {dn, ct, uk} = 3'b000;
    if (!i_nrst) begin
      foreach (mr[i]) mr[i] = 8'h00;
      {fl, ix, xl, rd} = '0;
    end else begin
      if (i_in_word_load) {xl, ix} = {i_in_word, i_in_index};
      dn = i_exec;
      if (i_exec) begin
        case (1'b1)
          i_ucode_word[15:12] == 4'h6: {mr[a], fl[7:6]} = {i_ucode_word[11:4],
            i_ucode_word[11], i_ucode_word[11:4] == 8'h00};
          i_ucode_word[15:8] == 8'h75: ix = mr[a][2:0];
          i_ucode_word[15:8] == 8'hee: xl = {mr[i_ucode_word[7:4]], mr[a]};
          i_ucode_word[15:8] == 8'h72: mr[a] = f;
          i_ucode_word[15:8] == 8'h73: begin
            fl[7:4] = mr[a][7:4];
            for (int i = 0; i < 4; i++) if (i_ucode_word[4+i]) fl[i] = mr[a][i];
          end
          i_ucode_word[15:9] == 7'h40 || i_ucode_word[15:9] == 7'h42: begin
            // opcode bit 10 separates the conditional form from the plain move
            ct = i_ucode_word[10] && f[0];
            if (!i_ucode_word[10] || f[0]) begin
              mr[a] = mr[i_ucode_word[7:4]];
              fl[7:6] = {mr[a][7], mr[a] == 8'h00};
              if (i_ucode_word[8]) fl[3:1] = {fl[7:6], 1'b0};
            end
          end
          default: uk = 1'b1;
        endcase
      end
      rd = mr[i_rd_indirect ? {i_rd_addr[3], ix} : i_rd_addr];
    end
  end
  always @(negedge i_clk) if (i_nrst) begin
    check(o_rd_data, rd);
    check(o_flags, fl);
    check(o_index, ix);
    check(o_xlate, xl);
    check(o_done, dn);
    check(o_cond_taken, ct);
    check(o_unknown_op, uk);
  end
  initial begin
    {i_nrst, i_in_word_load, i_rd_indirect, slow} = 4'h0;
    {i_in_word, i_in_index, i_rd_addr} = '0;
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    for (int n = 0; n < 800; n++) begin
      @(posedge i_clk);
      u_seq.q.push_back(mk({$random(seed)} % 9));
      i_in_word_load <= ($random(seed) & 7) == 0;
      i_in_word <= 16'($random(seed));
      i_in_index <= 3'($random(seed));
      i_rd_indirect <= ($random(seed) & 3) == 0;
      i_rd_addr <= 4'($random(seed) & 3);
      slow <= n >= 400;
    end
    while (u_seq.q.size() != 0) @(posedge i_clk);
    repeat (3) @(posedge i_clk);
    end_of_test();
  end
  initial begin
    #50000;
    miscompares++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
